// File: bench/ewd_prog_mem.sv
// Purpose: Program memory model offering instruction words to the decoder
// Assumes: Bench queues words; an offered word is held while busy is high
// Notes: With nothing to offer the word line flips each cycle, never stale
`timescale 1ns/100ps
module ewd_prog_mem (
  input wire logic i_clock,
  input wire logic i_busy,
  output logic o_word_valid,
  output logic [15:0] o_word
);
  logic [15:0] mem [0:1023];
  int wr_ptr = 0;
  int rd_ptr = 0;

  // Idle at time zero
  initial begin
    o_word_valid = 1'b0;
    o_word = 16'h0000;
  end

  // Queue one word behind the ones already waiting
  task automatic push(input logic [15:0] w);
    mem[wr_ptr[9:0]] = w;
    wr_ptr++;
  endtask

  // Busy is sampled at the edge, before the decoder's own update lands
  always @(posedge i_clock) begin
    if (o_word_valid && !i_busy) rd_ptr++;
    #1;
    o_word_valid = rd_ptr < wr_ptr;
    o_word = o_word_valid ? mem[rd_ptr[9:0]] : ~o_word; // Released line
  end
endmodule // ewd_prog_mem

// File: bench/testbench.sv
// Purpose: Self-checking bench for the extension word decoder
// Assumes: One instruction in flight at a time, inputs held through it
// Notes: Random mix from a fixed seed plus hand-picked corner cases
`timescale 1ns/100ps
module testbench;
  import ewd_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset_n, i_word_valid, i_carry;
  logic [15:0] i_word;
  logic [3:0] i_count_reg_low;
  logic [19:0] i_src_value, i_dst_value;
  logic o_busy, o_decode_valid, o_reg_mode, o_width_reserved, o_carry_zero;
  logic o_src_two_words, o_dst_two_words, o_exec_valid, o_exec_last, o_write_back;
  logic o_flag_v, o_flag_n, o_flag_z, o_flag_c;
  logic [3:0] o_count_reg_index, o_src_high, o_dst_high, o_flag_update;
  logic [4:0] o_repeat_n;
  logic [19:0] o_result;
  ewd_width_t o_width;
  ewd_op_t o_exec_op;
  int err_count = 0;
  int compares = 0;

  ewd_decoder u_dut (.i_clock, .i_reset_n, .i_word_valid, .i_word, .i_count_reg_low,
    .i_src_value, .i_dst_value, .i_carry, .o_busy, .o_count_reg_index, .o_decode_valid,
    .o_reg_mode, .o_width, .o_width_reserved, .o_carry_zero, .o_repeat_n, .o_src_high,
    .o_dst_high, .o_src_two_words, .o_dst_two_words, .o_exec_valid, .o_exec_op,
    .o_exec_last, .o_result, .o_write_back, .o_flag_update, .o_flag_v, .o_flag_n,
    .o_flag_z, .o_flag_c);
  ewd_prog_mem u_mem (.i_clock(i_clock), .i_busy(o_busy), .o_word_valid(i_word_valid),
    .o_word(i_word));

  // 125 MHz
  always #4 i_clock = ~i_clock;

  task automatic results;
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for a decode (ex=0) or execution (ex=1) pulse
  task automatic await(input logic ex);
    for (int i = 0; i < 50; i++) begin
      @(negedge i_clock);
      if ((ex ? o_exec_valid : o_decode_valid) === 1'b1) return;
    end
    chk(1'b1, 1'b0);
    results;
  endtask

  // Expected result and flags of one execution at the given width
  function automatic void alu(input ewd_op_t op, input ewd_width_t wd, input logic [19:0] s,
      input logic [19:0] d, input logic cy, output logic [19:0] r, output logic [3:0] f,
      output logic [3:0] u, output logic wr);
    logic [19:0] m, a;
    logic [20:0] t;
    logic [4:0] g;
    logic v, c;
    int mb;
    mb = (wd == EWD_W8) ? 7 : (wd == EWD_W16) ? 15 : 19;
    m = 20'hfffff >> (19 - mb);
    s = s & m;
    d = d & m;
    wr = (op != EWD_CMP) && (op != EWD_BIT);
    u = 4'hf;
    v = 1'b0;
    c = 1'b0;
    r = 20'h00000;
    case (op)
      EWD_MOV: begin r = s; u = 4'h0; end
      EWD_BIC: begin r = ~s & d; u = 4'h0; end
      EWD_BIS: begin r = s | d; u = 4'h0; end
      EWD_AND, EWD_BIT: r = s & d;
      EWD_XOR: begin r = s ^ d; v = s[mb] & d[mb]; end
      EWD_DADD: begin
        c = cy;
        for (int i = 0; i <= mb / 4; i++) begin
          g = s[4*i+:4] + d[4*i+:4] + c;
          c = g > 5'd9; // A digit above nine carries
          if (c) g = g + 5'h06;
          r[4*i+:4] = g[3:0];
        end
      end
      default: begin
        a = (op == EWD_ADD || op == EWD_ADDC) ? s : ~s & m;
        t = a + d + ((op == EWD_ADD) ? 1'b0 : (op == EWD_SUB || op == EWD_CMP) ? 1'b1 : cy);
        r = t[19:0] & m;
        c = t[mb + 1];
        v = (a[mb] == d[mb]) && (r[mb] != d[mb]);
      end
    endcase
    if (op inside {EWD_AND, EWD_BIT, EWD_XOR}) c = |r;
    f = {v, r[mb], r == 20'h00000, c};
  endfunction

  // Prefix then instruction; checks the decode and every execution
  task automatic run(input logic [15:0] p, input logic [15:0] w, input logic [19:0] sv,
      input logic [19:0] dv, input logic cin, input logic [3:0] rl);
    logic f2, regm, rsv, zc, cy, wr;
    ewd_width_t wd;
    logic [4:0] n;
    logic [19:0] d, r;
    logic [3:0] f, u;
    @(posedge i_clock);
    #1;
    i_src_value = sv;
    i_dst_value = dv;
    i_carry = cin;
    i_count_reg_low = rl;
    @(negedge i_clock);
    u_mem.push(p);
    u_mem.push(w);
    f2 = w[15:10] == EWD_FMT2_CODE;
    regm = (w[5:4] == 2'h0) && (f2 || !w[7]);
    zc = regm && p[8];
    rsv = (f2 && w[9:7] inside {EWD_F2_SWAP, EWD_F2_SEXT}) ? w[6] : !p[6] && !w[6];
    wd = rsv ? EWD_W16 : !p[6] ? EWD_W20 : w[6] ? EWD_W8 : EWD_W16;
    n = !regm ? 5'h01 : {1'b0, p[7] ? rl : p[3:0]} + 5'h01;
    await(1'b0);
    chk(o_count_reg_index, p[3:0]);
    chk(o_reg_mode, regm);
    chk(o_width_reserved, rsv);
    chk(20'(o_width), 20'(wd));
    chk(o_carry_zero, zc);
    chk(o_repeat_n, n);
    chk(o_src_high, regm ? 4'h0 : p[10:7]);
    chk(o_dst_high, regm ? 4'h0 : p[3:0]);
    chk(o_src_two_words, !f2 && !rsv && wd == EWD_W20 && w[5:4] != 2'h0);
    chk(o_dst_two_words, !rsv && wd == EWD_W20 && (f2 ? w[5:4] != 2'h0 : w[7]));
    chk(o_busy, !(f2 || rsv));
    if (f2 || rsv) begin
      @(negedge i_clock);
      chk(o_exec_valid, 1'b0);
    end else begin
      d = dv;
      cy = !zc && cin;
      for (int k = 0; k < n; k++) begin
        await(1'b1);
        alu(ewd_op_t'(w[15:12]), wd, sv, d, cy, r, f, u, wr);
        chk(o_exec_op, w[15:12]);
        chk(o_result, r);
        chk(o_write_back, wr);
        chk(o_flag_update, u);
        chk({o_flag_v, o_flag_n, o_flag_z, o_flag_c} & u, f & u);
        chk(o_exec_last, k == n - 1);
        chk(o_busy, k != n - 1);
        // Compare and bit-test leave the destination as it was
        if (wr) d = r;
        if (u[0] && !zc) cy = f[0];
      end
    end
  endtask

  // A word with no prefix before it must decode nothing
  task automatic quiet(input logic [15:0] w);
    @(negedge i_clock);
    u_mem.push(w);
    repeat (6) begin
      @(negedge i_clock);
      chk(o_decode_valid, 1'b0);
    end
  endtask

  // Reset, corner cases, then the random mix
  initial begin
    int seed;
    logic [31:0] rv, pv;
    logic [15:0] p, w;
    logic [3:0] op;
    logic [1:0] as_m;
    logic ad;
    seed = 55142;
    i_reset_n = 1'b0;
    i_carry = 1'b0;
    i_count_reg_low = 4'h0;
    i_src_value = 20'h00000;
    i_dst_value = 20'h00000;
    repeat (12) @(posedge i_clock);
    #1;
    i_reset_n = 1'b1;
    chk(20'(o_width), 20'(EWD_W16));
    chk(o_repeat_n, 5'h01);
    chk(o_busy, 1'b0);
    // Every operation at every width, reserved prefix bits set
    for (int o = 4; o < 16; o++)
      for (int k = 0; k < 3; k++)
        run(16'h1e30 | (k != 0 ? 16'h0040 : 16'h0000), {o[3:0], 4'h9, 1'b0, k != 1, 6'h08},
          20'h98765, 20'h45678, 1'b1, 4'h0);
    // Carry chaining over three executions, carry-zero set then clear
    for (int j = 0; j < 6; j++)
      run(16'h1842 | (j < 3 ? 16'h0100 : 16'h0000), {j % 3 == 0 ? 4'h6 : j % 3 == 1 ? 4'h7 :
        4'ha, 12'h908}, 20'h00999, 20'h00001, 1'b1, 4'h0);
    run(16'h184f, 16'h5102, 20'h01234, 20'h00000, 1'b0, 4'h0);
    quiet(16'h17ff);
    quiet(16'h5102);
    run(16'h18ca, 16'he102, 20'h0a5c3, 20'h0ffff, 1'b0, 4'h5);
    run(16'h1800, 16'h5102, 20'h00001, 20'h00002, 1'b0, 4'h0);
    for (int j = 0; j < 8; j++)
      run(16'h1800 | {9'h0, j[1], 6'h0}, {6'h04, j[2] ? 3'h3 : 3'h1, j[0], j[2], 5'h05},
        20'h00000, 20'h00000, 1'b0, 4'h0);
    run(16'h1d05, 16'h59d8, 20'h12345, 20'h00111, 1'b0, 4'h0);
    @(negedge i_clock);
    u_mem.push(16'h1fff);
    run(16'h1842, 16'h5102, 20'h00010, 20'h00020, 1'b0, 4'h0);
    // Random instructions in both prefix layouts
    for (int j = 0; j < 40; j++) begin
      rv = $random(seed);
      pv = $random(seed);
      op = 4'h4 + 4'(rv[7:0] % 8'd12);
      if (op == 4'ha) op = 4'h5;
      as_m = rv[20:19];
      ad = rv[18];
      if (rv[8]) begin
        ad = 1'b0;
        as_m = 2'h0;
      end else if (!ad && as_m == 2'h0) as_m = 2'h1;
      w = {op, rv[13:10], ad, rv[9], as_m, rv[17:14]};
      if (rv[8]) p = {5'h03, pv[10:0]} & ((op == 4'h9 || op == 4'hb) ? 16'hff70 : 16'hffff);
      else p = {5'h03, pv[10:6], 2'h0, pv[3:0]};
      run(p, w, 20'($random(seed)), 20'($random(seed)), pv[11], pv[15:12]);
    end
    results;
  end
endmodule // testbench

// File: hdl/ewd_alu.sv
// Purpose: Flag and result logic of the twelve widened two-operand operations
// Assumes: Carry input already chosen by the caller
// Notes: Purely combinational
`timescale 1ns/100ps
module ewd_alu (
  input wire ewd_pkg::ewd_op_t i_op,
  input wire ewd_pkg::ewd_width_t i_width,
  input wire logic [19:0] i_src,
  input wire logic [19:0] i_dst,
  input wire logic i_carry_in,
  output logic [19:0] o_result,
  output logic o_v,
  output logic o_n,
  output logic o_z,
  output logic o_c,
  output logic o_write,
  output logic [3:0] o_update
);
  import ewd_pkg::*;
  logic [19:0] mask;
  logic [19:0] s_m;
  logic [19:0] s_add;
  logic [19:0] d_m;
  logic [19:0] bcd;
  logic [20:0] sum;
  logic [5:0] dcar;
  logic [4:0] msb;
  logic cin;
  logic is_sub;
  logic dec_c;

  // Decimal digits, carry rippling upward
  assign dcar[0] = i_carry_in;
  genvar g;
  for (g = 0; g < 5; g++) begin : g_digit
    logic [4:0] raw;
    assign raw = {1'b0, d_m[4*g+3:4*g]} + {1'b0, s_m[4*g+3:4*g]} + {4'h0, dcar[g]};
    assign dcar[g+1] = raw > 5'd9;
    assign bcd[4*g+3:4*g] = dcar[g+1] ? 4'(raw + 5'd6) : raw[3:0];
  end

  // Width, operand shaping and flags
  always_comb begin
    case (i_width)
      EWD_W8: begin
        mask = 20'h000ff;
        msb = 5'd7;
        dec_c = dcar[2];
      end
      EWD_W16: begin
        mask = 20'h0ffff;
        msb = 5'd15;
        dec_c = dcar[4];
      end
      default: begin
        mask = 20'hfffff;
        msb = 5'd19;
        dec_c = dcar[5];
      end
    endcase
    d_m = i_dst & mask;
    s_m = i_src & mask;
    is_sub = (i_op == EWD_SUB) || (i_op == EWD_SUBC) || (i_op == EWD_CMP);
    s_add = is_sub ? (~i_src & mask) : s_m;
    cin = (i_op == EWD_SUB) || (i_op == EWD_CMP) ||
          (((i_op == EWD_ADDC) || (i_op == EWD_SUBC)) && i_carry_in);
    sum = {1'b0, d_m} + {1'b0, s_add} + {20'h00000, cin};
    o_result = sum[19:0] & mask;
    o_write = 1'b1;
    o_update = 4'hf;
    o_c = sum[msb+1];
    case (i_op)
      EWD_MOV: begin
        o_result = s_m;
        o_update = 4'h0;
      end
      EWD_CMP: o_write = 1'b0;
      EWD_DADD: o_result = bcd & mask;
      EWD_BIT: begin
        o_result = s_m & d_m;
        o_write = 1'b0;
      end
      EWD_BIC: begin
        o_result = ~i_src & d_m;
        o_update = 4'h0;
      end
      EWD_BIS: begin
        o_result = s_m | d_m;
        o_update = 4'h0;
      end
      EWD_XOR: o_result = s_m ^ d_m;
      EWD_AND: o_result = s_m & d_m;
      default: begin
      end
    endcase
    o_n = o_result[msb];
    o_z = (o_result == 20'h00000);
    o_v = (s_add[msb] == d_m[msb]) && (o_result[msb] != d_m[msb]);
    case (i_op)
      EWD_DADD: begin
        o_c = dec_c;
        o_v = 1'b0;
      end
      EWD_BIT, EWD_AND: begin
        o_c = !o_z;
        o_v = 1'b0;
      end
      EWD_XOR: begin
        o_c = !o_z;
        o_v = s_m[msb] && d_m[msb];
      end
      default: begin
      end
    endcase
  end
endmodule // ewd_alu

// File: hdl/ewd_decoder.sv
// Purpose: Catches the prefix word and widens the instruction after it
// Assumes: Words come from program memory on i_clock, no resync needed
// Notes: Words offered while o_busy is high are not taken
`timescale 1ns/100ps
module ewd_decoder (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_word_valid,
  input wire logic [15:0] i_word,
  input wire logic [3:0] i_count_reg_low,
  input wire logic [19:0] i_src_value,
  input wire logic [19:0] i_dst_value,
  input wire logic i_carry,
  output logic o_busy,
  output logic [3:0] o_count_reg_index,
  output logic o_decode_valid,
  output logic o_reg_mode,
  output ewd_pkg::ewd_width_t o_width,
  output logic o_width_reserved,
  output logic o_carry_zero,
  output logic [4:0] o_repeat_n,
  output logic [3:0] o_src_high,
  output logic [3:0] o_dst_high,
  output logic o_src_two_words,
  output logic o_dst_two_words,
  output logic o_exec_valid,
  output ewd_pkg::ewd_op_t o_exec_op,
  output logic o_exec_last,
  output logic [19:0] o_result,
  output logic o_write_back,
  output logic [3:0] o_flag_update,
  output logic o_flag_v,
  output logic o_flag_n,
  output logic o_flag_z,
  output logic o_flag_c
);
  import ewd_pkg::*;
  ewd_state_t state_q;
  logic [15:0] prefix_q;
  logic [4:0] left_q;
  logic first_q;
  logic [19:0] acc_q;
  logic carry_q;
  logic is_prefix;
  logic take;
  logic go;
  logic fmt1;
  logic fmt2;
  logic swap_ext;
  logic reg_mode;
  logic al;
  logic bw;
  logic [1:0] as_mode;
  logic ad_mode;
  ewd_width_t width_d;
  logic reserved_d;
  logic [3:0] count_d;
  logic start_d;
  logic [19:0] alu_dst;
  logic alu_cin;
  logic [19:0] alu_res;
  logic alu_v;
  logic alu_n;
  logic alu_z;
  logic alu_c;
  logic alu_write;
  logic [3:0] alu_update;

  // Prefix recognition on the op-code field alone
  assign is_prefix = (i_word[EWD_CODE_MSB:EWD_CODE_LSB] == EWD_PREFIX_CODE);
  assign take = i_word_valid && !o_busy;
  assign go = (state_q == EWD_HOLD) && take && !is_prefix;

  // Classify the word after the prefix
  always_comb begin
    fmt1 = (i_word[15:EWD_OPC_LSB] >= 4'h4);
    fmt2 = (i_word[15:10] == EWD_FMT2_CODE);
    swap_ext = fmt2 && ((i_word[9:7] == EWD_F2_SWAP) || (i_word[9:7] == EWD_F2_SEXT));
    as_mode = i_word[EWD_AS_LSB+1:EWD_AS_LSB];
    ad_mode = i_word[EWD_AD_BIT];
    reg_mode = fmt1 ? (as_mode == 2'h0) && !ad_mode : (as_mode == 2'h0);
    al = prefix_q[EWD_AL_BIT];
    bw = i_word[EWD_BW_BIT];
    width_d = EWD_W16;
    reserved_d = 1'b0;
    if (swap_ext) begin
      // Only 00 and 10 are meaningful here
      if (!al && !bw) begin
        width_d = EWD_W20;
      end else if (al && !bw) begin
        width_d = EWD_W16;
      end else begin
        reserved_d = 1'b1;
      end
    end else begin
      case ({al, bw})
        2'b01: width_d = EWD_W20;
        2'b10: width_d = EWD_W16;
        2'b11: width_d = EWD_W8;
        default: reserved_d = 1'b1;
      endcase
    end
    // Register count read through the index captured with the prefix
    count_d = prefix_q[EWD_RPT_BIT] ? i_count_reg_low :
              prefix_q[EWD_CNT_LSB+3:EWD_CNT_LSB];
    if (!reg_mode) begin
      count_d = 4'h0; // Address layout has no repeat field
    end
    start_d = fmt1 && !reserved_d;
  end

  // Sequencer: wait for prefix, hold it one word, then repeat
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_q <= EWD_IDLE;
    end else begin
      case (state_q)
        EWD_IDLE: begin
          if (take && is_prefix) begin
            state_q <= EWD_HOLD;
          end
        end
        EWD_HOLD: begin
          if (go) begin
            state_q <= start_d ? EWD_EXEC : EWD_IDLE;
          end
        end
        EWD_EXEC: begin
          if (left_q == 5'h01) begin
            state_q <= EWD_IDLE;
          end
        end
        default: state_q <= EWD_IDLE;
      endcase
    end
  end

  // Prefix store; wiped once the next word is used so it never leaks
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      prefix_q <= EWD_PREFIX_RST;
      o_count_reg_index <= 4'h0;
    end else if (take && is_prefix && (state_q != EWD_EXEC)) begin
      prefix_q <= i_word;
      o_count_reg_index <= i_word[EWD_CNT_LSB+3:EWD_CNT_LSB];
    end else if (go) begin
      prefix_q <= EWD_PREFIX_RST;
    end
  end

  // Decode result, one pulse per prefixed instruction
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_decode_valid <= 1'b0;
      o_reg_mode <= 1'b0;
      o_width <= EWD_W16;
      o_width_reserved <= 1'b0;
      o_carry_zero <= 1'b0;
      o_repeat_n <= EWD_REP_RST;
      o_src_high <= 4'h0;
      o_dst_high <= 4'h0;
      o_src_two_words <= 1'b0;
      o_dst_two_words <= 1'b0;
    end else begin
      o_decode_valid <= go;
      if (go) begin
        o_reg_mode <= reg_mode;
        o_width <= width_d;
        o_width_reserved <= reserved_d;
        // Bits 5:4 of the prefix are never looked at; bits 10:9 only feed o_src_high in the address layout
        o_carry_zero <= reg_mode && prefix_q[EWD_ZC_BIT];
        o_repeat_n <= {1'b0, count_d} + 5'h01;
        o_src_high <= reg_mode ? 4'h0 : prefix_q[EWD_SRC_HI_LSB+3:EWD_SRC_HI_LSB];
        o_dst_high <= reg_mode ? 4'h0 : prefix_q[EWD_DST_HI_LSB+3:EWD_DST_HI_LSB];
        // Wide operand held in memory spans two words
        o_src_two_words <= (width_d == EWD_W20) && !reserved_d && fmt1 &&
                           (as_mode != 2'h0);
        o_dst_two_words <= (width_d == EWD_W20) && !reserved_d &&
                           (fmt1 ? ad_mode : (fmt2 && (as_mode != 2'h0)));
      end
    end
  end

  // Operation latch and repeat counter
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_exec_op <= EWD_MOV;
      left_q <= 5'h00;
      first_q <= 1'b0;
    end else if (go) begin
      o_exec_op <= ewd_op_t'(i_word[15:EWD_OPC_LSB]);
      left_q <= {1'b0, count_d} + 5'h01;
      first_q <= 1'b1;
    end else if (state_q == EWD_EXEC) begin
      left_q <= left_q - 5'h01;
      first_q <= 1'b0;
    end
  end

  // Repeats chain on their own result and carry
  assign alu_dst = first_q ? i_dst_value : acc_q;
  assign alu_cin = o_carry_zero ? 1'b0 : (first_q ? i_carry : carry_q);

  ewd_alu u_alu (
    .i_op(o_exec_op),
    .i_width(o_width),
    .i_src(i_src_value),
    .i_dst(alu_dst),
    .i_carry_in(alu_cin),
    .o_result(alu_res),
    .o_v(alu_v),
    .o_n(alu_n),
    .o_z(alu_z),
    .o_c(alu_c),
    .o_write(alu_write),
    .o_update(alu_update)
  );

  // Execution outputs, one pulse per repetition
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_exec_valid <= 1'b0;
      o_exec_last <= 1'b0;
      o_result <= EWD_DATA_RST;
      o_write_back <= 1'b0;
      o_flag_update <= 4'h0;
      o_flag_v <= 1'b0;
      o_flag_n <= 1'b0;
      o_flag_z <= 1'b0;
      o_flag_c <= 1'b0;
    end else begin
      o_exec_valid <= (state_q == EWD_EXEC);
      o_exec_last <= (state_q == EWD_EXEC) && (left_q == 5'h01);
      if (state_q == EWD_EXEC) begin
        o_result <= alu_res;
        o_write_back <= alu_write;
        o_flag_update <= alu_update;
        o_flag_v <= alu_v;
        o_flag_n <= alu_n;
        o_flag_z <= alu_z;
        o_flag_c <= alu_c;
      end
    end
  end

  // Running destination and carry between repetitions
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      acc_q <= EWD_DATA_RST;
      carry_q <= 1'b0;
    end else if (state_q == EWD_EXEC) begin
      acc_q <= alu_write ? alu_res : alu_dst;
      carry_q <= alu_update[0] ? alu_c : alu_cin;
    end
  end

  // Busy while repeating; the memory must hold its word
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (go && start_d) || ((state_q == EWD_EXEC) && (left_q != 5'h01));
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  // Executions counted since the start, for the repeat check
  logic [4:0] seen_q;
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || go) begin
      seen_q <= 5'h00;
    end else if (o_exec_valid) begin
      seen_q <= seen_q + 5'h01;
    end
  end

  sequence s_start;
    go && start_d;
  endsequence
  sequence s_first_exec;
    (state_q == EWD_EXEC) ##1 o_exec_valid;
  endsequence

  chk_prefix_caught: assert property (
    (state_q == EWD_IDLE) && take && (i_word >= 16'h1800) && (i_word <= 16'h1fff)
    |=> state_q == EWD_HOLD) else $error("prefix word not held");
  chk_exec_follows: assert property (
    s_start |=> s_first_exec) else $error("execution did not start");
  chk_byte_width: assert property (
    go && !swap_ext && al && bw |=> o_width == EWD_W8 && !o_width_reserved)
    else $error("byte width not chosen");
  chk_reserved_code: assert property (
    go && !swap_ext && !al && !bw |=> o_width_reserved && o_width == EWD_W16
    ##1 !o_exec_valid) else $error("reserved width not handled");
  chk_imm_count: assert property (
    go && reg_mode && !prefix_q[EWD_RPT_BIT]
    |=> o_repeat_n == {1'b0, $past(prefix_q[3:0])} + 5'h01) else $error("bad immediate count");
  chk_reg_count: assert property (
    go && reg_mode && prefix_q[EWD_RPT_BIT]
    |=> o_repeat_n == {1'b0, $past(i_count_reg_low)} + 5'h01) else $error("bad register count");
  chk_exec_total: assert property (
    o_exec_valid && o_exec_last |-> seen_q + 5'h01 == o_repeat_n) else $error("wrong repeat total");
  chk_source_high: assert property (
    go && !reg_mode |=> o_src_high == $past(prefix_q[10:7]) && o_dst_high == $past(prefix_q[3:0]))
    else $error("high address bits lost");
  chk_prefix_drop: assert property (
    go |=> prefix_q == EWD_PREFIX_RST && state_q != EWD_HOLD) else $error("prefix retained");
  chk_flags_kept: assert property (
    o_exec_valid && (o_exec_op inside {EWD_MOV, EWD_BIC, EWD_BIS}) |-> o_flag_update == 4'h0)
    else $error("flags touched");
  chk_and_carry: assert property (
    o_exec_valid && (o_exec_op == EWD_AND) |-> o_flag_c == (o_result != 20'h00000) && !o_flag_v)
    else $error("and flags wrong");
endmodule // ewd_decoder

// File: hdl/ewd_pkg.sv
// Purpose: Shared constants and types for the extension word decoder
// Assumes: 16-bit instruction words, 20-bit operands
// Notes: Field positions refer to the prefix word or the word after it
package ewd_pkg;
  // Prefix op-code field, words 1800h..1fffh
  localparam logic [4:0] EWD_PREFIX_CODE = 5'h03;
  localparam int EWD_CODE_MSB = 15;
  localparam int EWD_CODE_LSB = 11;
  // Prefix fields
  localparam int EWD_ZC_BIT = 8;
  localparam int EWD_RPT_BIT = 7;
  localparam int EWD_AL_BIT = 6;
  localparam int EWD_SRC_HI_LSB = 7;
  localparam int EWD_DST_HI_LSB = 0;
  localparam int EWD_CNT_LSB = 0;
  // Following instruction fields
  localparam int EWD_BW_BIT = 6;
  localparam int EWD_AD_BIT = 7;
  localparam int EWD_AS_LSB = 4;
  localparam int EWD_OPC_LSB = 12;
  localparam logic [5:0] EWD_FMT2_CODE = 6'h04;
  localparam logic [2:0] EWD_F2_SWAP = 3'h1;
  localparam logic [2:0] EWD_F2_SEXT = 3'h3;
  // Reset values
  localparam logic [15:0] EWD_PREFIX_RST = 16'h0000;
  localparam logic [19:0] EWD_DATA_RST = 20'h00000;
  localparam logic [4:0] EWD_REP_RST = 5'h01;

  typedef enum logic [1:0] {
    EWD_W16 = 2'h0,
    EWD_W8 = 2'h1,
    EWD_W20 = 2'h2
  } ewd_width_t;

  typedef enum logic [3:0] {
    EWD_MOV = 4'h4, EWD_ADD = 4'h5, EWD_ADDC = 4'h6, EWD_SUBC = 4'h7,
    EWD_SUB = 4'h8, EWD_CMP = 4'h9, EWD_DADD = 4'ha, EWD_BIT = 4'hb,
    EWD_BIC = 4'hc, EWD_BIS = 4'hd, EWD_XOR = 4'he, EWD_AND = 4'hf
  } ewd_op_t;

  typedef enum logic [1:0] {
    EWD_IDLE = 2'h0,
    EWD_HOLD = 2'h1,
    EWD_EXEC = 2'h3
  } ewd_state_t;
endpackage
